// ==== hw/power_domain_pkg.sv ====
// Purpose: constants for the power domain enable and analog gain control block
// Assumes: 32-bit AXI4-Lite register access, 125 MHz aclk
// Notes: register offsets are byte addresses, one aligned word each
//
// Function
// RQ1: control-interface logic is powered whenever the power-up pin is high.
// RQ2: decoder logic runs only with power-up pin and decoder enable bit.
// RQ3: decoder enable output pin is high while the decoder condition holds.
// RQ4: crystal oscillator runs whenever the power-up pin is high.
// RQ5: IF input section runs only with power-up pin and decoder enable bit.
// RQ6: audio DAC, switching, volume and amplifier need the audio power bit.
// RQ7: nothing is active while the power-up pin is low.
// RQ8: analog gain is readable by software as signal strength indication.
// RQ9: analog gain spans 31 dB, time constant selectable per use case.
// RQ10: controller watches gain for overflow, may add external 20 dB step.
// RQ11: domain enables are plain AND of pin and bits, no sequencing delay.
package power_domain_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [7:0] GLOBAL_CONFIG_OFS = 8'h00;
    localparam logic [7:0] AGC_CONTROL_OFS = 8'h04;
    localparam logic [7:0] GAIN_READBACK_OFS = 8'h08;
    localparam logic [7:0] POWER_STATUS_OFS = 8'h0C;
    localparam int ADDR_W = 8;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int DECODER_ENABLE_POS = 0;
    localparam int AUDIO_POWER_POS = 1;
    localparam int TC_SEL_LSB = 0;
    localparam int AGC_HOLD_POS = 2;
    localparam int GAIN_LSB = 0;
    localparam int OVF_LIVE_POS = 8;
    localparam int OVF_STICKY_POS = 8;

    // ************************************************************
    // gain and reset values
    // ************************************************************
    localparam int GAIN_W = 5;
    localparam logic [4:0] GAIN_MAX_DB = 5'h1F;
    localparam logic [4:0] GAIN_RESET = 5'h1F;
    localparam logic [1:0] TC_SEL_RESET = 2'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ************************************************************
    // agc step periods
    // ************************************************************
    localparam int CLK_MHZ = 125;
    localparam int TC_STATIONARY_US = 1000;
    localparam int TC_HANDHELD_US = 100;
    localparam int TC_MOBILE_US = 10;
    localparam int TICK_W = 24;

    typedef enum logic [1:0] {TC_STATIONARY, TC_HANDHELD, TC_MOBILE} agc_tc_t;

endpackage

// ==== hw/power_domain_enable_ctrl.sv ====
// Purpose: per-domain power enables, register file and stepped analog gain control
// Assumes: inputs synchronous to aclk, synchronous active-low reset
// Notes: enables are combinational from pin and register bits
module power_domain_enable_ctrl #(
    parameter int STEP_STATIONARY_CYC =
        power_domain_pkg::TC_STATIONARY_US * power_domain_pkg::CLK_MHZ,
    parameter int STEP_HANDHELD_CYC =
        power_domain_pkg::TC_HANDHELD_US * power_domain_pkg::CLK_MHZ,
    parameter int STEP_MOBILE_CYC =
        power_domain_pkg::TC_MOBILE_US * power_domain_pkg::CLK_MHZ
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [power_domain_pkg::ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    // axi4-lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // axi4-lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [power_domain_pkg::ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    // axi4-lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // power pin and domain enables
    input wire logic power_up_pin,
    output logic ctrl_if_en,
    output logic osc_en,
    output logic decoder_en,
    output logic if_input_en,
    output logic audio_en,
    output logic decoder_enable_pin,
    // if level detector and gain to the analog stage
    input wire logic if_level_high,
    input wire logic if_level_low,
    output logic [power_domain_pkg::GAIN_W-1:0] agc_gain
);
    import power_domain_pkg::*;

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic dec_bit;
        logic aud_bit;
        logic [1:0] tc_sel;
        logic agc_hold;
        logic [GAIN_W-1:0] gain;
        logic [TICK_W-1:0] tick;
        logic ovf_sticky;
        logic aw_held;
        logic [ADDR_W-1:0] awaddr;
        logic w_held;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } state_t;

    localparam state_t STATE_RESET = '{
        dec_bit: 1'b0, aud_bit: 1'b0, tc_sel: TC_SEL_RESET, agc_hold: 1'b0,
        gain: GAIN_RESET, tick: '0, ovf_sticky: 1'b0, aw_held: 1'b0,
        awaddr: '0, w_held: 1'b0, wdata: '0, wstrb: '0, bvalid: 1'b0,
        bresp: RESP_OKAY, rvalid: 1'b0, rresp: RESP_OKAY, rdata: '0};

    state_t st_r;
    state_t st_nxt;

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic reg_mapped(input logic [ADDR_W-1:0] a);
        reg_mapped = (a == GLOBAL_CONFIG_OFS) || (a == AGC_CONTROL_OFS)
            || (a == GAIN_READBACK_OFS) || (a == POWER_STATUS_OFS);
    endfunction

    function automatic logic [TICK_W-1:0] step_period(input logic [1:0] sel);
        case (sel)
            TC_STATIONARY: step_period = TICK_W'(STEP_STATIONARY_CYC);
            TC_HANDHELD: step_period = TICK_W'(STEP_HANDHELD_CYC);
            default: step_period = TICK_W'(STEP_MOBILE_CYC);
        endcase
    endfunction

    logic ovf_live;
    logic do_write;
    logic step_now;

    // ************************************************************
    // power domain enables
    // ************************************************************
    assign ctrl_if_en = power_up_pin; // RQ1 RQ7
    assign osc_en = power_up_pin; // RQ4 RQ7
    assign decoder_en = power_up_pin & st_r.dec_bit; // RQ2 RQ11
    assign if_input_en = power_up_pin & st_r.dec_bit; // RQ5 RQ11
    assign audio_en = power_up_pin & st_r.aud_bit; // RQ6 RQ7 RQ11
    assign decoder_enable_pin = decoder_en; // RQ3

    // ************************************************************
    // bus outputs
    // ************************************************************
    assign awready = !st_r.aw_held && !st_r.bvalid;
    assign wready = !st_r.w_held && !st_r.bvalid;
    assign bvalid = st_r.bvalid;
    assign bresp = st_r.bresp;
    assign arready = !st_r.rvalid;
    assign rvalid = st_r.rvalid;
    assign rdata = st_r.rdata;
    assign rresp = st_r.rresp;
    assign agc_gain = st_r.gain;

    // overload with no gain left to drop
    assign ovf_live = if_input_en && if_level_high && (st_r.gain == '0);
    assign do_write = st_r.aw_held && st_r.w_held && !st_r.bvalid;
    assign step_now = if_input_en && !st_r.agc_hold && (st_r.tick == '0);

    // ************************************************************
    // next state
    // ************************************************************
    always_comb
    begin
        st_nxt = st_r;
        // write channel capture, either order
        if (awvalid && awready)
        begin
            st_nxt.aw_held = 1'b1;
            st_nxt.awaddr = awaddr;
        end
        if (wvalid && wready)
        begin
            st_nxt.w_held = 1'b1;
            st_nxt.wdata = wdata;
            st_nxt.wstrb = wstrb;
        end
        if (bvalid && bready)
        begin
            st_nxt.bvalid = 1'b0;
        end
        // gain control: step down on overload, up on weak level
        if (!if_input_en)
        begin
            st_nxt.gain = GAIN_RESET;
            st_nxt.tick = '0;
        end
        else if (st_r.agc_hold)
        begin
            st_nxt.tick = '0;
        end
        else if (step_now)
        begin
            st_nxt.tick = step_period(st_r.tc_sel) - TICK_W'(1); // RQ9
            if (if_level_high && st_r.gain != '0)
            begin
                st_nxt.gain = st_r.gain - GAIN_W'(1); // RQ9
            end
            else if (if_level_low && !if_level_high && st_r.gain != GAIN_MAX_DB)
            begin
                st_nxt.gain = st_r.gain + GAIN_W'(1); // RQ9
            end
        end
        else
        begin
            st_nxt.tick = st_r.tick - TICK_W'(1);
        end
        // register write, takes effect on the next edge
        if (do_write)
        begin
            st_nxt.aw_held = 1'b0;
            st_nxt.w_held = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = reg_mapped(st_r.awaddr) ? RESP_OKAY : RESP_SLVERR;
            if (st_r.wstrb[0])
            begin
                case (st_r.awaddr)
                    GLOBAL_CONFIG_OFS:
                    begin
                        st_nxt.dec_bit = st_r.wdata[DECODER_ENABLE_POS]; // RQ11
                        st_nxt.aud_bit = st_r.wdata[AUDIO_POWER_POS]; // RQ11
                    end
                    AGC_CONTROL_OFS:
                    begin
                        st_nxt.tc_sel = st_r.wdata[TC_SEL_LSB +: 2]; // RQ9
                        st_nxt.agc_hold = st_r.wdata[AGC_HOLD_POS];
                    end
                    default:
                    begin
                    end
                endcase
            end
            if (st_r.wstrb[1] && st_r.awaddr == POWER_STATUS_OFS
                && st_r.wdata[OVF_STICKY_POS])
            begin
                st_nxt.ovf_sticky = 1'b0;
            end
        end
        // a new overflow beats a clear in the same cycle
        if (ovf_live)
        begin
            st_nxt.ovf_sticky = 1'b1; // RQ10
        end
        // read channel
        if (rvalid && rready)
        begin
            st_nxt.rvalid = 1'b0;
        end
        if (arvalid && arready)
        begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp = reg_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
            st_nxt.rdata = '0;
            case (araddr)
                GLOBAL_CONFIG_OFS:
                begin
                    st_nxt.rdata[DECODER_ENABLE_POS] = st_r.dec_bit;
                    st_nxt.rdata[AUDIO_POWER_POS] = st_r.aud_bit;
                end
                AGC_CONTROL_OFS:
                begin
                    st_nxt.rdata[TC_SEL_LSB +: 2] = st_r.tc_sel;
                    st_nxt.rdata[AGC_HOLD_POS] = st_r.agc_hold;
                end
                GAIN_READBACK_OFS:
                begin
                    st_nxt.rdata[GAIN_LSB +: GAIN_W] = st_r.gain; // RQ8
                    st_nxt.rdata[OVF_LIVE_POS] = ovf_live; // RQ10
                end
                POWER_STATUS_OFS:
                begin
                    st_nxt.rdata[5:0] = {decoder_enable_pin, audio_en, if_input_en,
                        decoder_en, osc_en, ctrl_if_en};
                    st_nxt.rdata[OVF_STICKY_POS] = st_r.ovf_sticky;
                end
                default:
                begin
                end
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_r <= STATE_RESET;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    ctrl_if_on_a: assert property (ctrl_if_en == power_up_pin) // RQ1
        else $error("control interface enable does not follow power-up pin");
    decoder_gate_a: assert property (decoder_en |-> power_up_pin && st_r.dec_bit) // RQ2
        else $error("decoder enabled without pin and bit");
    dec_pin_a: assert property (decoder_enable_pin == (power_up_pin && st_r.dec_bit)) // RQ3
        else $error("decoder enable pin wrong");
    osc_on_a: assert property (power_up_pin |-> osc_en) // RQ4
        else $error("oscillator off while powered up");
    if_gate_a: assert property (if_input_en == decoder_en) // RQ5
        else $error("if input enable differs from decoder enable");
    audio_gate_a: assert property (audio_en |-> st_r.aud_bit && power_up_pin) // RQ6
        else $error("audio enabled without audio power bit");
    all_off_a: assert property (!power_up_pin |->
        !(ctrl_if_en || osc_en || decoder_en || if_input_en || audio_en)) // RQ7
        else $error("domain active with power-up pin low");
    gain_read_a: assert property (arvalid && arready && araddr == GAIN_READBACK_OFS
        |=> rvalid && rdata[GAIN_LSB +: GAIN_W] == $past(st_r.gain)) // RQ8
        else $error("gain readback wrong");
    gain_step_a: assert property (st_r.gain != $past(st_r.gain) && $past(if_input_en)
        |-> $past(step_now)) // RQ9
        else $error("gain moved outside a step tick");
    write_effect_a: assert property (do_write && st_r.wstrb[0]
        && st_r.awaddr == GLOBAL_CONFIG_OFS && power_up_pin
        ##1 power_up_pin |-> decoder_en == $past(st_r.wdata[DECODER_ENABLE_POS])) // RQ11
        else $error("config write did not reach decoder enable next cycle");

endmodule

// ==== tb/axi_master_model.sv ====
// Purpose: register bus master standing in for the external controller
// Assumes: slave answers in its own time, bench watchdog bounds every wait
// Notes: signals change by nonblocking assignment just after a rising edge
module axi_master_model (
    // clock
    input wire logic aclk,
    // write
    output logic awvalid,
    input wire logic awready,
    output logic [power_domain_pkg::ADDR_W-1:0] awaddr,
    output logic wvalid,
    input wire logic wready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic bready,
    input wire logic bvalid,
    input wire logic [1:0] bresp,
    // read
    output logic arvalid,
    input wire logic arready,
    output logic [power_domain_pkg::ADDR_W-1:0] araddr,
    output logic rready,
    input wire logic rvalid,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp
);
    timeunit 1ns;
    timeprecision 1ps;
    import power_domain_pkg::*;

    // ************************************************************
    // bus cycles
    // ************************************************************
    initial {awvalid, wvalid, bready, arvalid, rready} = '0;
    initial {awaddr, araddr, wdata, wstrb} = '0;

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [1:0] r);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= d;
        wstrb <= s;
        bready <= 1'b1;
        while (!done)
        begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid)
            begin
                done = 1'b1;
                r = bresp;
                bready <= 1'b0;
            end
        end
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        while (!done)
        begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid)
            begin
                done = 1'b1;
                d = rdata;
                r = rresp;
                rready <= 1'b0;
            end
        end
    endtask

    // overload check the controller runs before adding tuner attenuation
    task automatic watch_overflow(output logic ovf);
        logic [31:0] d;
        logic [1:0] r;
        rd(GAIN_READBACK_OFS, d, r);
        ovf = d[OVF_LIVE_POS];
    endtask
endmodule

// ==== tb/tb_top.sv ====
// Purpose: self-checking bench for the power domain enable block
// Assumes: shortened agc step periods 8, 4 and 2 cycles
// Notes: enables are read back both at the pins and in the status word
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import power_domain_pkg::*;

    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic power_up_pin = 1'b0;
    logic if_level_high = 1'b0;
    logic if_level_low = 1'b0;
    logic ctrl_if_en, osc_en, decoder_en, if_input_en, audio_en, decoder_enable_pin;
    logic [GAIN_W-1:0] agc_gain;
    int error_cnt = 0;
    int tests_run = 0;
    localparam int P[3] = '{8, 4, 2};

    always #4 aclk = ~aclk;

    power_domain_enable_ctrl #(.STEP_STATIONARY_CYC(8), .STEP_HANDHELD_CYC(4),
        .STEP_MOBILE_CYC(2)) u_dut (.aclk, .aresetn, .awvalid, .awready, .awaddr,
        .awprot(3'h0), .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp,
        .arvalid, .arready, .araddr, .arprot(3'h0), .rvalid, .rready, .rdata, .rresp,
        .power_up_pin, .ctrl_if_en, .osc_en, .decoder_en, .if_input_en, .audio_en,
        .decoder_enable_pin, .if_level_high, .if_level_low, .agc_gain);

    axi_master_model u_bus (.aclk, .awvalid, .awready, .awaddr, .wvalid, .wready,
        .wdata, .wstrb, .bready, .bvalid, .bresp, .arvalid, .arready, .araddr,
        .rready, .rvalid, .rdata, .rresp);

    // ************************************************************
    // helpers
    // ************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask

    task automatic wreg(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic [1:0] r;
        u_bus.wr(a, d, 4'hF, r);
        chk({30'h0, r}, {30'h0, er});
    endtask

    task automatic rreg(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        u_bus.rd(a, d, r);
        chk(d, exp);
        chk({30'h0, r}, {30'h0, er});
    endtask

    // same bit order as the status word
    function automatic logic [31:0] en();
        return {26'h0, decoder_enable_pin, audio_en, if_input_en, decoder_en, osc_en, ctrl_if_en};
    endfunction

    task automatic set_pin(input logic v, input logic [31:0] exp);
        @(posedge aclk);
        power_up_pin <= v;
        #1;
        chk(en(), exp);
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_reset;
        chk(en(), 32'h0000_0000);
        chk({27'h0, agc_gain}, 32'h0000_001F);
        rreg(GLOBAL_CONFIG_OFS, 32'h0000_0000, RESP_OKAY);
        rreg(AGC_CONTROL_OFS, 32'h0000_0000, RESP_OKAY);
        set_pin(1'b1, 32'h0000_0003);
        rreg(POWER_STATUS_OFS, 32'h0000_0003, RESP_OKAY);
    endtask

    task automatic t_domains;
        wreg(GLOBAL_CONFIG_OFS, 32'h0000_0001, RESP_OKAY);
        chk(en(), 32'h0000_002F);
        wreg(GLOBAL_CONFIG_OFS, 32'h0000_0002, RESP_OKAY);
        chk(en(), 32'h0000_0013);
        wreg(GLOBAL_CONFIG_OFS, 32'h0000_0003, RESP_OKAY);
        rreg(POWER_STATUS_OFS, 32'h0000_003F, RESP_OKAY);
        set_pin(1'b0, 32'h0000_0000);
        rreg(POWER_STATUS_OFS, 32'h0000_0000, RESP_OKAY);
        set_pin(1'b1, 32'h0000_003F);
        wreg(GLOBAL_CONFIG_OFS, 32'h0000_0000, RESP_OKAY);
    endtask

    task automatic t_agc_tc;
        for (int tc = 0; tc < 3; tc++)
        begin
            wreg(AGC_CONTROL_OFS, tc, RESP_OKAY);
            wreg(GLOBAL_CONFIG_OFS, 32'h0000_0001, RESP_OKAY);
            @(posedge aclk);
            if_level_high <= 1'b1;
            repeat (10 * P[tc]) @(posedge aclk);
            // ten steps down from full gain, one per period
            chk({27'h0, agc_gain}, 32'h0000_0015);
            if_level_high <= 1'b0;
            wreg(GLOBAL_CONFIG_OFS, 32'h0000_0000, RESP_OKAY);
            repeat (2) @(posedge aclk);
            chk({27'h0, agc_gain}, 32'h0000_001F);
        end
    endtask

    task automatic t_ovf;
        logic o;
        wreg(GLOBAL_CONFIG_OFS, 32'h0000_0001, RESP_OKAY);
        if_level_high <= 1'b1;
        repeat (80) @(posedge aclk);
        chk({27'h0, agc_gain}, 32'h0000_0000);
        rreg(GAIN_READBACK_OFS, 32'h0000_0100, RESP_OKAY);
        u_bus.watch_overflow(o);
        chk({31'h0, o}, 32'h0000_0001);
        rreg(POWER_STATUS_OFS, 32'h0000_012F, RESP_OKAY);
        if_level_high <= 1'b0;
        if_level_low <= 1'b1;
        repeat (80) @(posedge aclk);
        rreg(GAIN_READBACK_OFS, 32'h0000_001F, RESP_OKAY);
        wreg(POWER_STATUS_OFS, 32'h0000_0100, RESP_OKAY);
        rreg(POWER_STATUS_OFS, 32'h0000_002F, RESP_OKAY);
        wreg(AGC_CONTROL_OFS, 32'h0000_0006, RESP_OKAY);
        if_level_low <= 1'b0;
        if_level_high <= 1'b1;
        repeat (20) @(posedge aclk);
        chk({27'h0, agc_gain}, 32'h0000_001F);
        if_level_high <= 1'b0;
        wreg(8'h10, 32'hFFFF_FFFF, RESP_SLVERR);
        rreg(8'h10, 32'h0000_0000, RESP_SLVERR);
        rreg(GLOBAL_CONFIG_OFS, 32'h0000_0001, RESP_OKAY);
    endtask

    task automatic give_verdict;
        if (error_cnt == 0 && tests_run > 0)
        begin
            $display("*** PASS ***");
        end
        else
        begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial
    begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset;
        t_domains;
        t_agc_tc;
        t_ovf;
        give_verdict;
    end

    initial
    begin
        repeat (5000) @(posedge aclk);
        error_cnt++;
        give_verdict;
    end
endmodule
